// ---- core/blsc_pkg.sv ----
// constants shared by the bcd logic and step control block
package blsc_pkg;

	// ---------------------------------------------------------------
	// instruction function codes (decimal 04, 05, 41, 42, 43, 44)
	// ---------------------------------------------------------------
	localparam logic [7:0] FN_STEP_DEFINE   = 8'h04;
	localparam logic [7:0] FN_SECTION_LAUNCH = 8'h05;
	localparam logic [7:0] FN_SUBTRACT      = 8'h29;
	localparam logic [7:0] FN_WORD_CONJ     = 8'h2A;
	localparam logic [7:0] FN_WORD_DISJ     = 8'h2B;
	localparam logic [7:0] FN_CARRY_CLEAR   = 8'h2C;

	// ---------------------------------------------------------------
	// widths and flag addresses
	// ---------------------------------------------------------------
	localparam int          WORD_W          = 16;
	localparam int          DIGITS          = 4;
	localparam int          CTRL_BITS       = 16;
	localparam logic [15:0] CARRY_FLAG_ADDR = 16'h0312;
	localparam logic [15:0] START_FLAG_ADDR = 16'h0411;

	// ---------------------------------------------------------------
	// register map (byte addresses) and field positions
	// ---------------------------------------------------------------
	localparam logic [3:0] REG_STATUS  = 4'h0;
	localparam logic [3:0] REG_CONTROL = 4'h4;
	localparam logic [3:0] REG_RESULT  = 4'h8;
	localparam logic [3:0] REG_CTRLWD  = 4'hC;
	localparam int         ST_CARRY    = 0;
	localparam int         ST_FAULT    = 1;
	localparam int         ST_ZERO     = 2;
	localparam int         ST_START    = 3;
	localparam int         ST_STEPPING = 4;
	localparam int         ST_DOUBLE   = 5;
	localparam int         CT_CLR_FAULT = 0;
	localparam int         CT_CLR_CARRY = 1;
	localparam int         CT_CLR_CHECK = 2;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [31:0] RESET_DATA = 32'h0000_0000;

	typedef enum logic [0:0]
	{
		BLSC_LADDER   = 1'b0,
		BLSC_STEPPING = 1'b1
	} blsc_mode_type;

endpackage

// ---- core/blsc_bcd_sub.sv ----
// four digit bcd subtractor with borrow in and digit validity check
`timescale 1ns/1ps
`default_nettype none
module blsc_bcd_sub
(
	// operands
	input  wire logic [15:0] mi,
	input  wire logic [15:0] su,
	input  wire logic        cin,
	// answer
	output logic      [15:0] diff,
	output logic             borrow,
	output logic             bad
);
	logic [4:0] chain;
	logic [3:0] bad_d;

	assign chain[0] = cin;

	// digit ripple: 10000 + mi - su - cin, borrow out marks negative
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_digit
			logic [4:0] raw;
			assign raw = {1'b0, mi[4*g +: 4]} - {1'b0, su[4*g +: 4]} - {4'h0, chain[g]};
			assign chain[g+1] = raw[4];
			assign diff[4*g +: 4] = raw[4] ? 4'(raw[3:0] + 4'hA) : raw[3:0];
			assign bad_d[g] = (mi[4*g +: 4] > 4'h9) || (su[4*g +: 4] > 4'h9);
		end
	endgenerate

	assign borrow = chain[4];
	assign bad    = |bad_d;
endmodule
`default_nettype wire

// ---- core/blsc_core.sv ----
// execution unit for bcd subtract, word logic and step sequencing
// Functional notes
// - subtract with condition ON writes minuend minus subtrahend minus carry
// - subtract forms 10000 plus minuend less subtrahend less carry, four digits kept
// - negative answer sets carry and leaves ten's complement
// - non-bcd minuend or subtrahend turns fault flag ON
// - missing indirect retentive word turns fault flag ON
// - zero flag ON exactly when written result is zero
// - word conjunction with condition ON writes bitwise AND
// - word disjunction with condition ON writes bitwise OR
// - step define takes no condition; control bit alone governs the body
// - bit ON runs body, ON to OFF interlocks, OFF makes body no-op
// - section launch with condition ON starts the step of its control bit
// - a step never launched never runs its body
// - stepping continues until step define without control bit
// - step ends on next launch or bit OFF; outputs off, timers reload
// - counters, shift registers and latches keep state at step end
// - double output flagged only for ordinary and step use of one bit
// - step start flag ON for one scan after step define
// - carry flag is bit 0312; carry clear forces it OFF
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module blsc_core
(
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RESET,
	// instruction from the program scan
	input  wire logic        INSTR_VALID,
	input  wire logic [7:0]  INSTR_CODE,
	input  wire logic        EXEC_COND,
	input  wire logic [15:0] OPERAND_A,
	input  wire logic [15:0] OPERAND_B,
	input  wire logic        PTR_FAULT,
	input  wire logic [3:0]  CTRL_IDX,
	input  wire logic        CTRL_NONE,
	input  wire logic        SCAN_END,
	// program check
	input  wire logic        CHK_USE,
	input  wire logic        CHK_STEP,
	input  wire logic [3:0]  CHK_IDX,
	// results and flags
	output logic      [15:0] RESULT_WORD,
	output logic             RESULT_WRITE,
	output logic             CARRY_FLAG,
	output logic             FAULT_FLAG,
	output logic             ZERO_FLAG,
	output logic             STEP_START_FLAG,
	output logic             STEP_BODY_ENABLE,
	output logic             STEP_INTERLOCK,
	output logic             STEP_OUTPUTS_OFF,
	output logic             TIMER_PRESET_RELOAD,
	output logic      [15:0] CONTROL_WORD,
	output logic             DOUBLE_OUTPUT_ERROR,
	// avalon-mm slave
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed
	{
		logic [15:0]             res;
		logic                    res_we;
		logic                    carry;
		logic                    fault;
		logic                    zero;
		logic                    start_flag;
		logic                    start_seen;
		blsc_pkg::blsc_mode_type mode;
		logic [3:0]              act_idx;
		logic                    act_valid;
		logic                    body_en;
		logic                    interlock;
		logic                    outs_off;
		logic                    tmr_reload;
		logic [15:0]             ctrl;
		logic [15:0]             prev_on;
		logic [15:0]             use_ord;
		logic [15:0]             use_stp;
		logic                    dbl_err;
		logic                    ack;
		logic                    waitreq;
		logic [31:0]             rdata;
	} blsc_state_type;

	blsc_state_type st_r;
	blsc_state_type st_nxt;

	logic [15:0] sub_diff;
	logic        sub_borrow;
	logic        sub_bad;
	logic        run_ok;
	logic        bus_req;
	logic        bus_wr;

	blsc_bcd_sub u_sub
	(
		.mi     (OPERAND_A),
		.su     (OPERAND_B),
		.cin    (st_r.carry),
		.diff   (sub_diff),
		.borrow (sub_borrow),
		.bad    (sub_bad)
	);

	// ladder outside steps always runs; inside, only an enabled body
	assign run_ok  = (st_r.mode == blsc_pkg::BLSC_LADDER) || st_r.body_en;
	assign bus_req = AVS_READ || AVS_WRITE;
	assign bus_wr  = AVS_WRITE && st_r.ack && (AVS_ADDRESS == blsc_pkg::REG_CONTROL)
	               && AVS_BYTEENABLE[0];

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		st_nxt            = st_r;
		st_nxt.res_we     = 1'b0;
		st_nxt.interlock  = 1'b0;
		st_nxt.outs_off   = 1'b0;
		st_nxt.tmr_reload = 1'b0;

		// software clears first so a same-cycle event wins
		if (bus_wr && AVS_WRITEDATA[blsc_pkg::CT_CLR_FAULT])
			st_nxt.fault = 1'b0;
		if (bus_wr && AVS_WRITEDATA[blsc_pkg::CT_CLR_CARRY])
			st_nxt.carry = 1'b0;
		if (bus_wr && AVS_WRITEDATA[blsc_pkg::CT_CLR_CHECK])
		begin
			st_nxt.use_ord = blsc_pkg::RESET_WORD;
			st_nxt.use_stp = blsc_pkg::RESET_WORD;
			st_nxt.dbl_err = 1'b0;
		end

		if (SCAN_END)
		begin
			st_nxt.start_flag = st_r.start_seen;
			st_nxt.start_seen = 1'b0;
		end

		if (INSTR_VALID)
		begin
			case (INSTR_CODE)
				blsc_pkg::FN_SUBTRACT:
				begin
					if (EXEC_COND && run_ok)
					begin
						st_nxt.fault = sub_bad || PTR_FAULT;
						if (!(sub_bad || PTR_FAULT))
						begin
							st_nxt.res    = sub_diff;
							st_nxt.res_we = 1'b1;
							st_nxt.carry  = sub_borrow;
							st_nxt.zero   = (sub_diff == blsc_pkg::RESET_WORD);
						end
					end
				end
				blsc_pkg::FN_WORD_CONJ, blsc_pkg::FN_WORD_DISJ:
				begin
					if (EXEC_COND && run_ok)
					begin
						st_nxt.fault = PTR_FAULT;
						if (!PTR_FAULT)
						begin
							st_nxt.res    = (INSTR_CODE == blsc_pkg::FN_WORD_CONJ)
							              ? (OPERAND_A & OPERAND_B) : (OPERAND_A | OPERAND_B);
							st_nxt.res_we = 1'b1;
							st_nxt.zero   = (st_nxt.res == blsc_pkg::RESET_WORD);
						end
					end
				end
				blsc_pkg::FN_CARRY_CLEAR:
				begin
					if (EXEC_COND && run_ok)
						st_nxt.carry = 1'b0;
				end
				blsc_pkg::FN_SECTION_LAUNCH:
				begin
					if (EXEC_COND && run_ok)
					begin
						if (st_r.act_valid && st_r.ctrl[st_r.act_idx]
						    && (st_r.act_idx != CTRL_IDX))
						begin
							st_nxt.ctrl[st_r.act_idx] = 1'b0;
							st_nxt.outs_off           = 1'b1;
							st_nxt.tmr_reload         = 1'b1;
						end
						st_nxt.ctrl[CTRL_IDX] = 1'b1;
						st_nxt.mode           = blsc_pkg::BLSC_STEPPING;
					end
				end
				blsc_pkg::FN_STEP_DEFINE:
				begin
					if (CTRL_NONE)
					begin
						st_nxt.mode      = blsc_pkg::BLSC_LADDER;
						st_nxt.act_valid = 1'b0;
						st_nxt.body_en   = 1'b0;
					end
					else
					begin
						st_nxt.act_idx   = CTRL_IDX;
						st_nxt.act_valid = 1'b1;
						st_nxt.mode      = blsc_pkg::BLSC_STEPPING;
						st_nxt.body_en   = st_r.ctrl[CTRL_IDX];
						st_nxt.prev_on[CTRL_IDX] = st_r.ctrl[CTRL_IDX];
						if (!st_r.ctrl[CTRL_IDX] && st_r.prev_on[CTRL_IDX])
						begin
							// bit OFF ends step, counters untouched
							st_nxt.interlock  = 1'b1;
							st_nxt.outs_off   = 1'b1;
							st_nxt.tmr_reload = 1'b1;
						end
						if (st_r.ctrl[CTRL_IDX])
							st_nxt.start_seen = 1'b1;
					end
				end
				default:
				begin
					st_nxt.res_we = 1'b0;
				end
			endcase
		end

		// double output only when ordinary and step use meet
		if (CHK_USE)
		begin
			if (CHK_STEP)
				st_nxt.use_stp[CHK_IDX] = 1'b1;
			else
				st_nxt.use_ord[CHK_IDX] = 1'b1;
		end
		// a software clear of the check drops the uses it is clearing as well
		if (|(st_r.use_ord & st_r.use_stp)
		    && !(bus_wr && AVS_WRITEDATA[blsc_pkg::CT_CLR_CHECK]))
			st_nxt.dbl_err = 1'b1;

		// bus: one wait cycle, then the answer
		st_nxt.ack     = bus_req && !st_r.ack;
		st_nxt.waitreq = !st_nxt.ack;
		if (AVS_READ && !st_r.ack)
		begin
			case (AVS_ADDRESS)
				blsc_pkg::REG_STATUS:
					st_nxt.rdata = {26'h0, st_r.dbl_err, st_r.mode == blsc_pkg::BLSC_STEPPING,
					                st_r.start_flag, st_r.zero, st_r.fault, st_r.carry};
				blsc_pkg::REG_RESULT:
					st_nxt.rdata = {16'h0, st_r.res};
				blsc_pkg::REG_CTRLWD:
					st_nxt.rdata = {16'h0, st_r.ctrl};
				default:
					st_nxt.rdata = blsc_pkg::RESET_DATA;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
		begin
			st_r      <= '0;
			st_r.mode <= blsc_pkg::BLSC_LADDER;
			st_r.waitreq <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	assign RESULT_WORD         = st_r.res;
	assign RESULT_WRITE        = st_r.res_we;
	assign CARRY_FLAG          = st_r.carry;
	assign FAULT_FLAG          = st_r.fault;
	assign ZERO_FLAG           = st_r.zero;
	assign STEP_START_FLAG     = st_r.start_flag;
	assign STEP_BODY_ENABLE    = st_r.body_en;
	assign STEP_INTERLOCK      = st_r.interlock;
	assign STEP_OUTPUTS_OFF    = st_r.outs_off;
	assign TIMER_PRESET_RELOAD = st_r.tmr_reload;
	assign CONTROL_WORD        = st_r.ctrl;
	assign DOUBLE_OUTPUT_ERROR = st_r.dbl_err;
	assign AVS_READDATA        = st_r.rdata;
	assign AVS_WAITREQUEST     = st_r.waitreq;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);

	logic sub_go;
	logic ok_go;
	assign sub_go = INSTR_VALID && (INSTR_CODE == blsc_pkg::FN_SUBTRACT) && EXEC_COND && run_ok;
	assign ok_go  = !sub_bad && !PTR_FAULT;

	property p_sub_off;
		INSTR_VALID && (INSTR_CODE == blsc_pkg::FN_SUBTRACT) && !EXEC_COND |=> !RESULT_WRITE;
	endproperty
	a_sub_off: assert property (p_sub_off) else $error("subtract ran with condition off");

	property p_sub_val;
		logic [15:0] d;
		(sub_go && ok_go, d = sub_diff) |=> RESULT_WRITE && (RESULT_WORD == d);
	endproperty
	a_sub_val: assert property (p_sub_val) else $error("subtract result wrong");

	property p_sub_carry;
		logic neg;
		(sub_go && ok_go, neg = ({1'b0, OPERAND_A} < ({1'b0, OPERAND_B} + {16'h0000, CARRY_FLAG})))
		|=> CARRY_FLAG == neg;
	endproperty
	a_sub_carry: assert property (p_sub_carry) else $error("negative answer without carry");

	property p_bcd_fault;
		sub_go && sub_bad |=> FAULT_FLAG && !RESULT_WRITE;
	endproperty
	a_bcd_fault: assert property (p_bcd_fault) else $error("non-bcd operand not flagged");

	property p_ptr_fault;
		INSTR_VALID && EXEC_COND && run_ok && PTR_FAULT
		&& ((INSTR_CODE == blsc_pkg::FN_WORD_DISJ) || (INSTR_CODE == blsc_pkg::FN_WORD_CONJ)
		    || (INSTR_CODE == blsc_pkg::FN_SUBTRACT))
		|=> FAULT_FLAG && !RESULT_WRITE;
	endproperty
	a_ptr_fault: assert property (p_ptr_fault) else $error("pointer fault not flagged");

	property p_zero;
		RESULT_WRITE |-> (ZERO_FLAG == (RESULT_WORD == 16'h0000));
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag disagrees with result");

	property p_conj;
		INSTR_VALID && (INSTR_CODE == blsc_pkg::FN_WORD_CONJ) && EXEC_COND && run_ok && !PTR_FAULT
		|=> RESULT_WORD == ($past(OPERAND_A) & $past(OPERAND_B));
	endproperty
	a_conj: assert property (p_conj) else $error("word and result wrong");

	property p_disj;
		INSTR_VALID && (INSTR_CODE == blsc_pkg::FN_WORD_DISJ) && EXEC_COND && run_ok && !PTR_FAULT
		|=> RESULT_WORD == ($past(OPERAND_A) | $past(OPERAND_B));
	endproperty
	a_disj: assert property (p_disj) else $error("word or result wrong");

	property p_body_off;
		INSTR_VALID && (INSTR_CODE == blsc_pkg::FN_STEP_DEFINE) && !CTRL_NONE && !CONTROL_WORD[CTRL_IDX]
		|=> !STEP_BODY_ENABLE;
	endproperty
	a_body_off: assert property (p_body_off) else $error("body enabled with bit off");

	property p_step_end;
		INSTR_VALID && (INSTR_CODE == blsc_pkg::FN_SECTION_LAUNCH) && EXEC_COND && run_ok
		&& st_r.act_valid && CONTROL_WORD[st_r.act_idx] && (st_r.act_idx != CTRL_IDX)
		|=> STEP_OUTPUTS_OFF && TIMER_PRESET_RELOAD && !CONTROL_WORD[$past(st_r.act_idx)];
	endproperty
	a_step_end: assert property (p_step_end) else $error("step did not end on launch");

	property p_start_flag;
		$rose(STEP_START_FLAG) |-> $past(SCAN_END);
	endproperty
	a_start_flag: assert property (p_start_flag) else $error("start flag rose mid scan");

	property p_carry_clr;
		INSTR_VALID && (INSTR_CODE == blsc_pkg::FN_CARRY_CLEAR) && EXEC_COND && run_ok
		|=> !CARRY_FLAG;
	endproperty
	a_carry_clr: assert property (p_carry_clr) else $error("carry not cleared");

	property p_bus;
		bus_req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
	endproperty
	a_bus: assert property (p_bus) else $error("bus answer late");

	c_neg_sub: cover property (sub_go && ok_go ##1 CARRY_FLAG);
	c_step_end: cover property (STEP_OUTPUTS_OFF);
	c_interlock: cover property (STEP_INTERLOCK);
	c_dbl: cover property ($rose(DOUBLE_OUTPUT_ERROR));
endmodule
`default_nettype wire

// ---- tb/blsc_testbench.sv ----
// self-checking bench for the bcd logic and step control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// clock, reset and design signals
	logic        REF_CLK = 1'b0;
	logic        RESET = 1'b1;
	logic        INSTR_VALID = 1'b0;
	logic [7:0]  INSTR_CODE = 8'h00;
	logic        EXEC_COND = 1'b0;
	logic [15:0] OPERAND_A = 16'h0000;
	logic [15:0] OPERAND_B = 16'h0000;
	logic        PTR_FAULT = 1'b0;
	logic [3:0]  CTRL_IDX = 4'h0;
	logic        CTRL_NONE = 1'b0;
	logic        SCAN_END = 1'b0;
	logic        CHK_USE = 1'b0;
	logic        CHK_STEP = 1'b0;
	logic [3:0]  CHK_IDX = 4'h0;
	logic [15:0] RESULT_WORD, CONTROL_WORD;
	logic        RESULT_WRITE, CARRY_FLAG, FAULT_FLAG, ZERO_FLAG, STEP_START_FLAG;
	logic        STEP_BODY_ENABLE, STEP_INTERLOCK, STEP_OUTPUTS_OFF, TIMER_PRESET_RELOAD;
	logic        DOUBLE_OUTPUT_ERROR, AVS_WAITREQUEST;
	logic [3:0]  AVS_ADDRESS = 4'h0;
	logic        AVS_READ = 1'b0;
	logic        AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
	logic [3:0]  AVS_BYTEENABLE = 4'hF;
	logic [31:0] AVS_READDATA, rd;
	int          err_count = 0;
	int          checks = 0;

	always #12.5 REF_CLK = ~REF_CLK;

	blsc_core i_dut (.REF_CLK(REF_CLK), .RESET(RESET), .INSTR_VALID(INSTR_VALID),
		.INSTR_CODE(INSTR_CODE), .EXEC_COND(EXEC_COND), .OPERAND_A(OPERAND_A),
		.OPERAND_B(OPERAND_B), .PTR_FAULT(PTR_FAULT), .CTRL_IDX(CTRL_IDX),
		.CTRL_NONE(CTRL_NONE), .SCAN_END(SCAN_END), .CHK_USE(CHK_USE), .CHK_STEP(CHK_STEP),
		.CHK_IDX(CHK_IDX), .RESULT_WORD(RESULT_WORD), .RESULT_WRITE(RESULT_WRITE),
		.CARRY_FLAG(CARRY_FLAG), .FAULT_FLAG(FAULT_FLAG), .ZERO_FLAG(ZERO_FLAG),
		.STEP_START_FLAG(STEP_START_FLAG), .STEP_BODY_ENABLE(STEP_BODY_ENABLE),
		.STEP_INTERLOCK(STEP_INTERLOCK), .STEP_OUTPUTS_OFF(STEP_OUTPUTS_OFF),
		.TIMER_PRESET_RELOAD(TIMER_PRESET_RELOAD), .CONTROL_WORD(CONTROL_WORD),
		.DOUBLE_OUTPUT_ERROR(DOUBLE_OUTPUT_ERROR), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST));

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("errors %0d comparisons %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// one instruction, result looked at 1 ns after the taking edge
	task automatic issue(input logic [7:0] code, input logic cond, input logic [15:0] a,
		input logic [15:0] b, input logic ptr, input logic [3:0] idx, input logic none);
		@(posedge REF_CLK);
		INSTR_VALID <= 1'b1;
		INSTR_CODE  <= code;
		EXEC_COND   <= cond;
		OPERAND_A   <= a;
		OPERAND_B   <= b;
		PTR_FAULT   <= ptr;
		CTRL_IDX    <= idx;
		CTRL_NONE   <= none;
		@(posedge REF_CLK);
		INSTR_VALID <= 1'b0;
		#1;
	endtask

	task automatic res(input logic wr, input logic [15:0] w, input logic cy, input logic ft,
		input logic zr);
		chk(RESULT_WRITE, wr, "write pulse");
		chk(RESULT_WORD, w, "result word");
		chk(CARRY_FLAG, cy, "carry");
		chk(FAULT_FLAG, ft, "fault");
		chk(ZERO_FLAG, zr, "zero");
	endtask

	task automatic avs(input logic wr, input logic [3:0] addr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge REF_CLK);
		AVS_READ      <= ~wr;
		AVS_WRITE     <= wr;
		AVS_ADDRESS   <= addr;
		AVS_WRITEDATA <= wd;
		do
		begin
			@(posedge REF_CLK);
			n++;
		end
		while (AVS_WAITREQUEST !== 1'b0);
		rd = AVS_READDATA;
		AVS_READ  <= 1'b0;
		AVS_WRITE <= 1'b0;
		if (n >= 50)
			chk(1'b1, 1'b0, "bus timeout");
	endtask

	task automatic pulse_scan();
		@(posedge REF_CLK);
		SCAN_END <= 1'b1;
		@(posedge REF_CLK);
		SCAN_END <= 1'b0;
		#1;
	endtask

	task automatic use_bit(input logic step, input logic [3:0] idx);
		@(posedge REF_CLK);
		CHK_USE  <= 1'b1;
		CHK_STEP <= step;
		CHK_IDX  <= idx;
		@(posedge REF_CLK);
		CHK_USE <= 1'b0;
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_regs_reset();
		avs(1'b0, 4'h0, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "status after reset");
		avs(1'b0, 4'h8, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "result after reset");
		avs(1'b1, 4'h1, 32'hFFFF_FFFF);
		avs(1'b0, 4'h1, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "unmapped read");
	endtask

	task automatic t_steps();
		issue(8'h05, 1'b1, 16'h0000, 16'h0000, 1'b0, 4'h3, 1'b0);
		chk(CONTROL_WORD, 16'h0008, "launch sets bit");
		issue(8'h04, 1'b0, 16'h0000, 16'h0000, 1'b0, 4'h3, 1'b0);
		chk(STEP_BODY_ENABLE, 1'b1, "body runs without condition");
		pulse_scan();
		chk(STEP_START_FLAG, 1'b1, "start flag on");
		pulse_scan();
		chk(STEP_START_FLAG, 1'b0, "start flag one scan");
		issue(8'h29, 1'b1, 16'h0500, 16'h0200, 1'b0, 4'h0, 1'b0);
		res(1'b1, 16'h0300, 1'b0, 1'b0, 1'b0);
		issue(8'h05, 1'b0, 16'h0000, 16'h0000, 1'b0, 4'h6, 1'b0);
		chk(CONTROL_WORD, 16'h0008, "launch with condition off");
		issue(8'h05, 1'b1, 16'h0000, 16'h0000, 1'b0, 4'h4, 1'b0);
		chk(CONTROL_WORD, 16'h0010, "next launch ends step");
		chk(STEP_OUTPUTS_OFF, 1'b1, "outputs off pulse");
		chk(TIMER_PRESET_RELOAD, 1'b1, "timer reload pulse");
		issue(8'h04, 1'b0, 16'h0000, 16'h0000, 1'b0, 4'h3, 1'b0);
		chk(STEP_INTERLOCK, 1'b1, "bit off interlocks step");
		chk(STEP_BODY_ENABLE, 1'b0, "body off after bit off");
		issue(8'h04, 1'b0, 16'h0000, 16'h0000, 1'b0, 4'h4, 1'b0);
		issue(8'h05, 1'b1, 16'h0000, 16'h0000, 1'b0, 4'h5, 1'b0);
		issue(8'h04, 1'b0, 16'h0000, 16'h0000, 1'b0, 4'h7, 1'b0);
		chk(STEP_BODY_ENABLE, 1'b0, "unlaunched step disabled");
		issue(8'h29, 1'b1, 16'h0900, 16'h0100, 1'b0, 4'h0, 1'b0);
		res(1'b0, 16'h0300, 1'b0, 1'b0, 1'b0);
		issue(8'h05, 1'b1, 16'h0000, 16'h0000, 1'b0, 4'h8, 1'b0);
		chk(CONTROL_WORD, 16'h0020, "launch in idle step ignored");
		issue(8'h04, 1'b0, 16'h0000, 16'h0000, 1'b0, 4'h0, 1'b1);
		issue(8'h29, 1'b1, 16'h0900, 16'h0100, 1'b0, 4'h0, 1'b0);
		res(1'b1, 16'h0800, 1'b0, 1'b0, 1'b0);
	endtask

	task automatic t_subtract();
		issue(8'h29, 1'b1, 16'h0089, 16'h0100, 1'b0, 4'h0, 1'b0);
		res(1'b1, 16'h9989, 1'b1, 1'b0, 1'b0);
		issue(8'h29, 1'b1, 16'h0000, 16'h9989, 1'b0, 4'h0, 1'b0);
		res(1'b1, 16'h0010, 1'b1, 1'b0, 1'b0);
		issue(8'h2C, 1'b1, 16'h0000, 16'h0000, 1'b0, 4'h0, 1'b0);
		chk(CARRY_FLAG, 1'b0, "carry cleared");
		issue(8'h29, 1'b1, 16'h0000, 16'h9989, 1'b0, 4'h0, 1'b0);
		res(1'b1, 16'h0011, 1'b1, 1'b0, 1'b0);
		issue(8'h2C, 1'b1, 16'h0000, 16'h0000, 1'b0, 4'h0, 1'b0);
		issue(8'h29, 1'b1, 16'h9876, 16'h1234, 1'b0, 4'h0, 1'b0);
		res(1'b1, 16'h8642, 1'b0, 1'b0, 1'b0);
		issue(8'h29, 1'b1, 16'h0200, 16'h0200, 1'b0, 4'h0, 1'b0);
		res(1'b1, 16'h0000, 1'b0, 1'b0, 1'b1);
		issue(8'h29, 1'b0, 16'h0500, 16'h0100, 1'b0, 4'h0, 1'b0);
		res(1'b0, 16'h0000, 1'b0, 1'b0, 1'b1);
		issue(8'h29, 1'b1, 16'h00A0, 16'h0001, 1'b0, 4'h0, 1'b0);
		res(1'b0, 16'h0000, 1'b0, 1'b1, 1'b1);
		issue(8'h29, 1'b1, 16'h0001, 16'h0B00, 1'b0, 4'h0, 1'b0);
		res(1'b0, 16'h0000, 1'b0, 1'b1, 1'b1);
		issue(8'h29, 1'b1, 16'h0003, 16'h0001, 1'b1, 4'h0, 1'b0);
		res(1'b0, 16'h0000, 1'b0, 1'b1, 1'b1);
	endtask

	task automatic t_logic();
		issue(8'h2A, 1'b1, 16'hF0F0, 16'h0F0F, 1'b0, 4'h0, 1'b0);
		res(1'b1, 16'h0000, 1'b0, 1'b0, 1'b1);
		issue(8'h2B, 1'b1, 16'h1A00, 16'h00B4, 1'b0, 4'h0, 1'b0);
		res(1'b1, 16'h1AB4, 1'b0, 1'b0, 1'b0);
		issue(8'h2A, 1'b1, 16'hFFFF, 16'h8001, 1'b0, 4'h0, 1'b0);
		res(1'b1, 16'h8001, 1'b0, 1'b0, 1'b0);
		issue(8'h2A, 1'b0, 16'h0000, 16'h0000, 1'b0, 4'h0, 1'b0);
		res(1'b0, 16'h8001, 1'b0, 1'b0, 1'b0);
		issue(8'h2B, 1'b0, 16'h0000, 16'h0000, 1'b0, 4'h0, 1'b0);
		res(1'b0, 16'h8001, 1'b0, 1'b0, 1'b0);
		issue(8'h2A, 1'b1, 16'h1111, 16'h1111, 1'b1, 4'h0, 1'b0);
		res(1'b0, 16'h8001, 1'b0, 1'b1, 1'b0);
		issue(8'h2B, 1'b1, 16'h1111, 16'h1111, 1'b1, 4'h0, 1'b0);
		res(1'b0, 16'h8001, 1'b0, 1'b1, 1'b0);
	endtask

	task automatic t_check();
		use_bit(1'b1, 4'h5);
		use_bit(1'b1, 4'h5);
		@(posedge REF_CLK);
		#1;
		chk(DOUBLE_OUTPUT_ERROR, 1'b0, "branching double start");
		use_bit(1'b0, 4'h2);
		use_bit(1'b1, 4'h2);
		@(posedge REF_CLK);
		#1;
		chk(DOUBLE_OUTPUT_ERROR, 1'b1, "ladder and step use");
	endtask

	task automatic t_regs_end();
		issue(8'h29, 1'b1, 16'h0000, 16'h0001, 1'b0, 4'h0, 1'b0);
		res(1'b1, 16'h9999, 1'b1, 1'b0, 1'b0);
		avs(1'b1, 4'h4, 32'h0000_0002);
		avs(1'b0, 4'h0, 32'h0000_0000);
		chk(rd, 32'h0000_0020, "status after carry clear");
		avs(1'b1, 4'h4, 32'h0000_0004);
		avs(1'b0, 4'h0, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "status after check clear");
		avs(1'b0, 4'h8, 32'h0000_0000);
		chk(rd, 32'h0000_9999, "result register");
		avs(1'b0, 4'hC, 32'h0000_0000);
		chk(rd, 32'h0000_0020, "control word register");
	endtask

	// ---------------------------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge REF_CLK);
		RESET <= 1'b0;
		t_regs_reset();
		t_steps();
		t_subtract();
		t_logic();
		t_check();
		t_regs_end();
		give_verdict();
	end

	initial
	begin
		#(25 * 5000);
		err_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
